// [rtl/dio_ioe_block.sv]
// Function
// - six registers plus latch per element
// - input clock and enable chosen separately
// - output and oe share clock and enable
// - one oe register takes falling edge
// - at most four elements per block
// - eight dedicated I/O clock lines
// - each element picks its own controls
// - every element input may be inverted
// - one clear/preset source, kind per element
// - power-up level pairs with clear/preset
// - synchronous reset input supported
// - ddr in, ddr out and bidirectional ddr
// - input registers sample opposite edges
// - latch aligns both bits to one edge
// - output registers load on rising edge
// - clock high sends first, low second
// - row feeds row/column/direct, column column only
// - pin buffer enable is active low
// - falling-edge oe delays enable to fall
`include "dio_defines.svh"

module dio_ioe_block
  import dio_pkg::*;
#(
  parameter bit ROW_BLOCK = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`DIO_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DIO_DW-1:0] pwdata,
  input wire logic [`DIO_NBYTES-1:0] pstrb,
  output logic [`DIO_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`DIO_NUM_CLK-1:0] io_clk_lines,
  input wire logic [`DIO_NUM_IOE-1:0] pin_in,
  input wire logic [`DIO_NUM_IOE-1:0] core_dataouta,
  input wire logic [`DIO_NUM_IOE-1:0] core_dataoutb,
  input wire logic [`DIO_NUM_IOE-1:0] core_oe,
  input wire logic [`DIO_NUM_IOE-1:0] core_ce_in,
  input wire logic [`DIO_NUM_IOE-1:0] core_ce_out,
  input wire logic [`DIO_NUM_IOE-1:0] core_aclr,
  input wire logic [`DIO_NUM_IOE-1:0] core_sclr,
  output logic [`DIO_NUM_IOE-1:0] pin_out,
  output logic [`DIO_NUM_IOE-1:0] pin_oe_n,
  output logic [`DIO_NUM_IOE-1:0] col_rx_a,
  output logic [`DIO_NUM_IOE-1:0] col_rx_b,
  output logic [`DIO_NUM_IOE-1:0] row_rx_a,
  output logic [`DIO_NUM_IOE-1:0] row_rx_b,
  output logic [`DIO_NUM_IOE-1:0] dlink_rx_a,
  output logic [`DIO_NUM_IOE-1:0] dlink_rx_b
);

  dio_top_s s_reg;
  dio_top_s s_next;
  logic [`DIO_NUM_CLK-1:0] clk_sync;
  logic [`DIO_NUM_IOE-1:0] pin_sync;
  logic cfg_hit;
  logic status_hit;
  logic [`DIO_LSEL_W-1:0] idx;
  logic wr_cfg;
  logic [`DIO_DW-1:0] status_word;
  logic [`DIO_DW-1:0] wcfg;

  // ****************************************************
  // synchronisers for the I/O clock lines and the pins
  // ****************************************************
  // the I/O clocks are sampled on pclk, so their edges are seen as
  // events; they must be well below half the pclk rate to be seen
  dio_sync #(
    .WIDTH(`DIO_NUM_CLK)
  ) u_clk_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(io_clk_lines),
    .q(clk_sync)
  );

  dio_sync #(
    .WIDTH(`DIO_NUM_IOE)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pin_in),
    .q(pin_sync)
  );

  // ****************************************************
  // one element step: selection, inversion, edges, registers
  // ****************************************************
  function automatic dio_elem_s dio_elem_step(
    input dio_elem_s e,
    input logic [`DIO_DW-1:0] c,
    input logic [`DIO_NUM_CLK-1:0] clks,
    input logic pin,
    input logic da,
    input logic db,
    input logic [`DIO_NUM_IOE-1:0] oe_l,
    input logic [`DIO_NUM_IOE-1:0] cei_l,
    input logic [`DIO_NUM_IOE-1:0] ceo_l,
    input logic [`DIO_NUM_IOE-1:0] aclr_l,
    input logic [`DIO_NUM_IOE-1:0] sclr_l,
    input logic cfg_wr
  );
    dio_elem_s n;
    logic [`DIO_W_INV-1:0] inv;
    logic lvl;
    logic ci;
    logic co;
    logic p;
    logic ce_i;
    logic ce_o;
    logic oe_in;
    logic ac;
    logic sc;
    logic ri;
    logic fi;
    logic ro;
    logic fo;
    begin
      n = e;
      inv = c[`DIO_F_INV +: `DIO_W_INV];
      lvl = c[`DIO_F_LVL];
      ci = clks[c[`DIO_F_CLKIN +: `DIO_CSEL_W]] ^ inv[`DIO_INV_CLKIN];
      co = clks[c[`DIO_F_CLKOUT +: `DIO_CSEL_W]] ^ inv[`DIO_INV_CLKOUT];
      ce_i = cei_l[c[`DIO_F_CEIN +: `DIO_LSEL_W]] ^ inv[`DIO_INV_CEIN];
      ce_o = ceo_l[c[`DIO_F_CEOUT +: `DIO_LSEL_W]] ^ inv[`DIO_INV_CEOUT];
      oe_in = oe_l[c[`DIO_F_OE +: `DIO_LSEL_W]] ^ inv[`DIO_INV_OE];
      ac = (aclr_l[c[`DIO_F_ACLR +: `DIO_LSEL_W]] ^ inv[`DIO_INV_ACLR]) & c[`DIO_F_ACLREN];
      sc = sclr_l[c[`DIO_F_SCLR +: `DIO_LSEL_W]] ^ inv[`DIO_INV_SCLR];
      p = pin ^ inv[`DIO_INV_PIN];
      ri = ci & ~e.clk_in_prev;
      fi = ~ci & e.clk_in_prev;
      ro = co & ~e.clk_out_prev;
      fo = ~co & e.clk_out_prev;
      n.clk_in_prev = ci;
      n.clk_out_prev = co;
      // input side
      if (ri && ce_i) begin
        if (sc) begin
          n.in_pos = lvl;
          n.rx_a = lvl;
          n.rx_b = lvl;
        end else begin
          n.in_pos = p;
          if (!c[`DIO_F_DDRIN]) begin
            n.rx_a = p;
            n.rx_b = p;
          end else if (!c[`DIO_F_ALIGNF]) begin
            n.rx_a = e.in_latch;
            n.rx_b = e.in_neg;
          end
        end
      end
      if (fi && ce_i && c[`DIO_F_DDRIN]) begin
        if (sc) begin
          n.in_neg = lvl;
          n.in_latch = lvl;
        end else begin
          n.in_neg = p;
          n.in_latch = e.in_pos;
          if (c[`DIO_F_ALIGNF]) begin
            n.rx_a = e.in_pos;
            n.rx_b = p;
          end
        end
      end
      // output and output-enable side
      if (ro && ce_o) begin
        if (sc) begin
          n.out_a = lvl;
          n.out_b = lvl;
          n.oe_pos = lvl;
        end else begin
          n.out_a = da ^ inv[`DIO_INV_DA];
          n.out_b = db ^ inv[`DIO_INV_DB];
          n.oe_pos = ~oe_in;
        end
      end
      if (fo && ce_o) begin
        n.oe_neg = sc ? lvl : e.oe_pos;
      end
      // the pin follows the held registers, mux steered by the clock level
      if (c[`DIO_F_DDROUT]) begin
        n.pin_out = co ? e.out_a : e.out_b;
      end else begin
        n.pin_out = e.out_a;
      end
      // with falling-edge oe on, either oe register being high holds the buffer off until the fall; otherwise only oe_pos counts
      n.pin_oe_n = c[`DIO_F_NEGOE] ? (e.oe_pos | e.oe_neg) : e.oe_pos;
      // clear or preset overrides any clock edge; a config write acts as power-up
      if (ac || cfg_wr) begin
        n.in_pos = lvl;
        n.in_neg = lvl;
        n.in_latch = lvl;
        n.rx_a = lvl;
        n.rx_b = lvl;
        n.out_a = lvl;
        n.out_b = lvl;
        n.oe_pos = lvl;
        n.oe_neg = lvl;
      end
      return n;
    end
  endfunction : dio_elem_step

  // ****************************************************
  // register decode
  // ****************************************************
  always_comb begin
    cfg_hit = ((paddr & `DIO_CFG_MASK) == `DIO_OFF_CFG0);
    status_hit = (paddr == `DIO_OFF_STATUS);
    idx = paddr[`DIO_IDX_LSB +: `DIO_LSEL_W];
    wr_cfg = psel & penable & s_reg.pready & pwrite & cfg_hit;
    status_word = `DIO_RDATA_RST;
    for (int i = 0; i < `DIO_NUM_IOE; i++) begin
      status_word[`DIO_ST_RXA + i] = s_reg.elem[i].rx_a;
      status_word[`DIO_ST_RXB + i] = s_reg.elem[i].rx_b;
      status_word[`DIO_ST_PIN + i] = s_reg.elem[i].pin_out;
      status_word[`DIO_ST_OEN + i] = s_reg.elem[i].pin_oe_n;
    end
    wcfg = s_reg.cfg[idx];
    for (int b = 0; b < `DIO_NBYTES; b++) begin
      if (pstrb[b]) begin
        wcfg[b*`DIO_BYTE +: `DIO_BYTE] = pwdata[b*`DIO_BYTE +: `DIO_BYTE];
      end
    end
  end

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    s_next = s_reg;
    // apb: answer is prepared in setup, presented in the access cycle
    if (psel && !penable) begin
      s_next.pready = 1'b1;
      s_next.pslverr = ~(cfg_hit | status_hit);
      if (pwrite) begin
        s_next.prdata = `DIO_RDATA_RST;
      end else if (cfg_hit) begin
        s_next.prdata = s_reg.cfg[idx];
      end else if (status_hit) begin
        s_next.prdata = status_word;
      end else begin
        s_next.prdata = `DIO_RDATA_RST;
      end
    end else begin
      s_next.pready = 1'b0;
      s_next.pslverr = 1'b0;
    end
    if (wr_cfg) begin
      s_next.cfg[idx] = wcfg;
    end
    // four elements, each with its own data bit and shared control lines
    for (int i = 0; i < `DIO_NUM_IOE; i++) begin
      s_next.elem[i] = dio_elem_step(
        s_reg.elem[i],
        s_next.cfg[i],
        clk_sync,
        pin_sync[i],
        core_dataouta[i],
        core_dataoutb[i],
        core_oe,
        core_ce_in,
        core_ce_out,
        core_aclr,
        core_sclr,
        wr_cfg && (idx == `DIO_LSEL_W'(i))
      );
      // column blocks have no row or direct-link reach
      s_next.row_a[i] = ROW_BLOCK & s_reg.elem[i].rx_a;
      s_next.row_b[i] = ROW_BLOCK & s_reg.elem[i].rx_b;
      s_next.dl_a[i] = ROW_BLOCK & s_reg.elem[i].rx_a;
      s_next.dl_b[i] = ROW_BLOCK & s_reg.elem[i].rx_b;
    end
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      for (int i = 0; i < `DIO_NUM_IOE; i++) begin
        s_reg.cfg[i] <= `DIO_CFG_RST;
        s_reg.elem[i].oe_pos <= `DIO_OE_OFF;
        s_reg.elem[i].oe_neg <= `DIO_OE_OFF;
        s_reg.elem[i].pin_oe_n <= `DIO_OE_OFF;
      end
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign row_rx_a = s_reg.row_a;
  assign row_rx_b = s_reg.row_b;
  assign dlink_rx_a = s_reg.dl_a;
  assign dlink_rx_b = s_reg.dl_b;

  always_comb begin
    for (int i = 0; i < `DIO_NUM_IOE; i++) begin
      pin_out[i] = s_reg.elem[i].pin_out;
      pin_oe_n[i] = s_reg.elem[i].pin_oe_n;
      col_rx_a[i] = s_reg.elem[i].rx_a;
      col_rx_b[i] = s_reg.elem[i].rx_b;
    end
  end

endmodule : dio_ioe_block

// [inc/dio_defines.svh]
`ifndef DIO_DEFINES_SVH
`define DIO_DEFINES_SVH

// ****************************************************
// block geometry
// ****************************************************
`define DIO_NUM_IOE 4
`define DIO_NUM_CLK 8
`define DIO_CSEL_W 3
`define DIO_LSEL_W 2
`define DIO_AW 8
`define DIO_DW 32
`define DIO_BYTE 8
`define DIO_NBYTES 4

// ****************************************************
// register offsets
// ****************************************************
`define DIO_OFF_CFG0 8'h00
`define DIO_CFG_MASK 8'hF3
`define DIO_IDX_LSB 2
`define DIO_OFF_STATUS 8'h10

// ****************************************************
// element configuration word fields
// ****************************************************
`define DIO_F_CLKIN 0
`define DIO_F_CLKOUT 3
`define DIO_F_OE 6
`define DIO_F_CEIN 8
`define DIO_F_CEOUT 10
`define DIO_F_ACLR 12
`define DIO_F_SCLR 14
`define DIO_F_LVL 16
`define DIO_F_DDRIN 17
`define DIO_F_DDROUT 18
`define DIO_F_NEGOE 19
`define DIO_F_ALIGNF 20
`define DIO_F_INV 21
`define DIO_W_INV 10
`define DIO_F_ACLREN 31

// ****************************************************
// inversion bits inside the inversion field
// ****************************************************
`define DIO_INV_DA 0
`define DIO_INV_DB 1
`define DIO_INV_OE 2
`define DIO_INV_CEIN 3
`define DIO_INV_CEOUT 4
`define DIO_INV_ACLR 5
`define DIO_INV_SCLR 6
`define DIO_INV_CLKIN 7
`define DIO_INV_CLKOUT 8
`define DIO_INV_PIN 9

// ****************************************************
// status word fields
// ****************************************************
`define DIO_ST_RXA 0
`define DIO_ST_RXB 4
`define DIO_ST_PIN 8
`define DIO_ST_OEN 12

// ****************************************************
// reset values
// ****************************************************
`define DIO_CFG_RST 32'h0000_0000
`define DIO_RDATA_RST 32'h0000_0000
`define DIO_OE_OFF 1'b1

`endif

// [inc/dio_pkg.sv]
`include "dio_defines.svh"

package dio_pkg;

  typedef struct packed {
    logic clk_in_prev;
    logic clk_out_prev;
    logic in_pos;
    logic in_neg;
    logic in_latch;
    logic rx_a;
    logic rx_b;
    logic out_a;
    logic out_b;
    logic oe_pos;
    logic oe_neg;
    logic pin_out;
    logic pin_oe_n;
  } dio_elem_s;

  typedef struct packed {
    dio_elem_s [`DIO_NUM_IOE-1:0] elem;
    logic [`DIO_NUM_IOE-1:0][`DIO_DW-1:0] cfg;
    logic [`DIO_DW-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [`DIO_NUM_IOE-1:0] row_a;
    logic [`DIO_NUM_IOE-1:0] row_b;
    logic [`DIO_NUM_IOE-1:0] dl_a;
    logic [`DIO_NUM_IOE-1:0] dl_b;
  } dio_top_s;

endpackage : dio_pkg

// [rtl/dio_sync.sv]
`include "dio_defines.svh"

module dio_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } dio_sync_s;

  dio_sync_s s_reg;
  dio_sync_s s_next;

  // first stage feeds the second stage only
  always_comb begin
    s_next = s_reg;
    s_next.s1 = d;
    s_next.s2 = s_reg.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.s2;

endmodule : dio_sync

// [tb/dio_ioe_block_chk.sv]
`include "dio_defines.svh"
module dio_ioe_block_chk #(
  parameter bit ROW_BLOCK = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`DIO_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic [`DIO_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [`DIO_NUM_IOE-1:0] col_rx_a,
  input wire logic [`DIO_NUM_IOE-1:0] col_rx_b,
  input wire logic [`DIO_NUM_IOE-1:0] row_rx_a,
  input wire logic [`DIO_NUM_IOE-1:0] row_rx_b,
  input wire logic [`DIO_NUM_IOE-1:0] dlink_rx_a,
  input wire logic [`DIO_NUM_IOE-1:0] dlink_rx_b
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic setup = psel && !penable;
  // ****
  // register bus answers
  // ****
  property p_rdy;
    setup |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_rdy1;
    pready |=> !pready;
  endproperty
  a_rdy1: assert property (p_rdy1) else $error("ready longer than one cycle");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_unmap;
    setup && paddr[7:2] > 6'h04 |=> pslverr && prdata == '0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
  property p_map;
    setup && paddr[7:2] <= 6'h04 && paddr[1:0] == 2'h0 |=> pready && !pslverr;
  endproperty
  a_map: assert property (p_map) else $error("mapped access refused");
  property p_hold;
    !$past(setup) |-> $stable(prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without setup");
  // ****
  // row routing copies
  // ****
  property p_rowa;
    row_rx_a == (ROW_BLOCK ? $past(col_rx_a) : '0) && dlink_rx_a == row_rx_a;
  endproperty
  a_rowa: assert property (p_rowa) else $error("row copy a wrong");
  property p_rowb;
    row_rx_b == (ROW_BLOCK ? $past(col_rx_b) : '0) && dlink_rx_b == row_rx_b;
  endproperty
  a_rowb: assert property (p_rowb) else $error("row copy b wrong");
endmodule : dio_ioe_block_chk

// [tb/dio_far_model.sv]
module dio_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] line_sel,
  input wire logic [3:0] tx_a,
  input wire logic [3:0] tx_b,
  output logic [7:0] io_clk_lines,
  output logic [3:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt;
  logic ck;
  // finishes its high phase before halting, so the clock always idles low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
      ck <= 1'b0;
    end else if (run || ck) begin
      cnt <= cnt + 3'h1;
      if (cnt == 3'h7) begin
        ck <= ~ck;
      end
    end
  end
  // only the chosen line toggles, so a wrong select sees no edges
  assign io_clk_lines = 8'(ck) << line_sel;
  assign pin_in = ck ? tx_a : tx_b;
endmodule : dio_far_model

// [tb/dio_ioe_block_test.sv]
`include "dio_defines.svh"
module dio_ioe_block_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, run, er;
  logic [7:0] paddr, io_clk_lines;
  logic [31:0] pwdata, prdata, rd, rv;
  logic [3:0] pstrb, xa, xb, da, db, m, pin_in, pin_out, pin_oe_n, col_rx_a, col_rx_b;
  logic [3:0] core_oe, core_ce_in, core_ce_out, core_aclr, core_sclr;
  logic [2:0] ln;
  logic [1:0] k;
  int err_count, samples_checked, cyc;
  wire logic ck = |io_clk_lines;
  dio_ioe_block dio_ioe_block_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .io_clk_lines, .pin_in, .core_dataouta(da), .core_dataoutb(db), .core_oe,
    .core_ce_in, .core_ce_out, .core_aclr, .core_sclr, .pin_out, .pin_oe_n, .col_rx_a, .col_rx_b,
    .row_rx_a(), .row_rx_b(), .dlink_rx_a(), .dlink_rx_b());
  dio_far_model dio_far_model_i (.pclk, .presetn, .run, .line_sel(ln), .tx_a(xa), .tx_b(xb),
    .io_clk_lines, .pin_in);
  always #50 pclk = ~pclk;
  // ****
  // helpers
  // ****
  task automatic stop_test;
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 10000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) o[b*8+:8] = n[b*8+:8];
    end
    return o;
  endfunction : merge
  // idle cycle at the end keeps psel from being set twice in one step
  // waits for ready with no cycle limit of its own; only the bench timeout ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : apb
  task automatic setall(input logic [31:0] c);
    for (int i = 0; i < 4; i++) apb(1'b1, 8'(i * 4), c, 4'hF);
  endtask : setall
  // ****
  // scenarios
  // ****
  initial begin
    {pclk, presetn, psel, penable, pwrite, run, paddr, pwdata, pstrb, xa, xb, da, db, ln, k} = '0;
    {core_oe, core_ce_in, core_ce_out, core_aclr, core_sclr} = '0;
    {err_count, samples_checked, cyc} = '0;
    rv = $urandom(55240);
    repeat (3) @(posedge pclk);
    chk(32'({pin_oe_n, pin_out, col_rx_a, col_rx_b}), 32'hF000);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      rv = $urandom;
      m = 4'($urandom);
      apb(1'b0, 8'(i * 4), '0, 4'h0);
      chk(rd, `DIO_CFG_RST);
      apb(1'b1, 8'(i * 4), rv, m);
      apb(1'b0, 8'(i * 4), '0, 4'h0);
      chk(rd, merge(`DIO_CFG_RST, rv, m));
    end
    apb(1'b0, 8'h14, '0, 4'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, 8'h40, '1, 4'hF);
    chk(32'(er), 32'h1);
    // double-rate capture, pin inversion, align edge, enable dropped
    for (int t = 0; t < 6; t++) begin
      {ln, k} = 5'($urandom);
      m = {4{t[1]}};
      setall({1'b0, t[1], 5'h0, t[2], 3'h0, t[0], 4'b0010, {5{k}}, ln, ln});
      core_ce_in <= t[2] ? ~(4'h1 << k) : 4'h1 << k;
      {xa, xb} <= 8'($urandom);
      run <= 1'b1;
      repeat (80) @(posedge pclk);
      chk(32'({col_rx_a, col_rx_b}), 32'({xa ^ m, xb ^ m}));
      core_ce_in <= {4{t[2]}};
      {xa, xb} <= ~{xa, xb};
      repeat (40) @(posedge pclk);
      chk(32'({col_rx_a, col_rx_b}), 32'({~xa ^ m, ~xb ^ m}));
    end
    // double-rate launch with data inversion
    for (int t = 0; t < 4; t++) begin
      {ln, k} = 5'($urandom);
      setall({8'h0, t[0], t[1:0], 5'b00100, {5{k}}, ln, ln});
      {core_oe, core_ce_out} <= {t[0] ? 4'h0 : 4'h1 << k, 4'h1 << k};
      {da, db} <= 8'($urandom);
      repeat (40) @(posedge pclk);
      @(posedge ck);
      repeat (7) @(posedge pclk);
      chk(32'({pin_out, pin_oe_n}), 32'({da ^ {4{t[0]}}, 4'h0}));
      @(negedge ck);
      repeat (7) @(posedge pclk);
      chk(32'(pin_out), 32'(db ^ {4{t[1]}}));
    end
    run <= 1'b0;
    repeat (20) @(posedge pclk);
    setall({12'h0, 4'b1101, {5{k}}, ln, ln});
    core_oe <= 4'h1 << k;
    // the pin enable trails the forced registers by one cycle
    @(posedge pclk);
    chk(32'(pin_oe_n), 32'hF);
    run <= 1'b1;
    @(posedge ck);
    repeat (7) @(posedge pclk);
    chk(32'(pin_oe_n), 32'hF);
    @(negedge ck);
    repeat (7) @(posedge pclk);
    chk(32'(pin_oe_n), 32'h0);
    // async force, read-only status, then synchronous reset
    for (int l = 0; l < 2; l++) begin
      setall({1'b1, 11'h0, 3'b110, l[0], {5{k}}, ln, ln});
      {da, db} <= {8{~l[0]}};
      {core_oe, core_ce_out, run} <= {l[0] ? 4'h1 << k : 4'h0, 4'h1 << k, 1'b1};
      repeat (40) @(posedge pclk);
      {core_ce_out, run} <= 5'h0;
      repeat (20) @(posedge pclk);
      chk(32'({pin_out, pin_oe_n}), 32'({8{~l[0]}}));
      core_aclr <= 4'h1 << k;
      repeat (3) @(posedge pclk);
      chk(32'({pin_out, pin_oe_n, col_rx_a, col_rx_b}), 32'({16{l[0]}}));
      apb(1'b1, `DIO_OFF_STATUS, '1, 4'hF);
      chk(32'(er), 32'h0);
      apb(1'b0, `DIO_OFF_STATUS, '0, 4'h0);
      chk(rd, {16'h0, {16{l[0]}}});
      {core_aclr, core_ce_out, run} <= {4'h0, 4'h1 << k, 1'b1};
      repeat (40) @(posedge pclk);
      chk(32'(pin_out), 32'({4{~l[0]}}));
      core_sclr <= 4'h1 << k;
      repeat (40) @(posedge pclk);
      chk(32'(pin_out), 32'({4{l[0]}}));
      {core_sclr, run} <= 5'h0;
      repeat (20) @(posedge pclk);
    end
    stop_test();
  end
endmodule : dio_ioe_block_test
bind dio_ioe_block dio_ioe_block_chk #(.ROW_BLOCK(ROW_BLOCK)) dio_ioe_block_chk_i (.pclk, .presetn, .paddr,
  .psel, .penable, .prdata, .pready, .pslverr, .col_rx_a, .col_rx_b, .row_rx_a, .row_rx_b, .dlink_rx_a,
  .dlink_rx_b);
